// [design/sensor_cfg_pkg.sv]
package sensor_cfg_pkg;
   // ----------------------------------------------------------------
   // device register map
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_PART_ID    = 7'h00;
   localparam logic [6:0] ADDR_REVISION   = 7'h01;
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h0A;
   localparam logic [6:0] ADDR_CONFIG     = 7'h15;
   localparam logic [6:0] ADDR_NV_WIRE    = 7'h35;
   localparam logic [7:0] SOFT_RESET_CODE = 8'h5A;
   localparam int         FOUR_WIRE_BIT   = 7;
   localparam int         RANGE_HI        = 4;
   localparam int         RANGE_LO        = 3;
   localparam logic [1:0] RANGE_2G        = 2'h0;
   localparam logic [1:0] RANGE_4G        = 2'h1;
   localparam logic [1:0] RANGE_8G        = 2'h2;
   localparam logic [1:0] RANGE_INVALID   = 2'h3;
   localparam logic [7:0] CFG_RESET       = 8'h00;
   localparam logic [7:0] NV_RESET        = 8'h00;
   localparam logic [7:0] ID_ALL_ONES     = 8'hFF;
   localparam logic [7:0] ID_ALL_ZEROS    = 8'h00;
   // ----------------------------------------------------------------
   // frame layout: read flag, 7 address bits, 8 data bits
   // ----------------------------------------------------------------
   localparam logic [3:0] LAST_ADDR_BIT   = 4'h7;
   localparam logic [3:0] LAST_FRAME_BIT  = 4'hF;
   localparam logic [4:0] FRAME_BITS      = 5'h10;
   // ----------------------------------------------------------------
   // host registers and timing
   // ----------------------------------------------------------------
   localparam logic [31:0] HOST_CMD_OFS    = 32'h0000_0000;
   localparam logic [31:0] HOST_STATUS_OFS = 32'h0000_0004;
   localparam int          CMD_READ_BIT    = 31;
   localparam int          CLK_PERIOD_NS   = 50;
   localparam int          NV_SETTLE_MS    = 30;
   localparam int          NV_SETTLE_CYC   = (NV_SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int          SCK_HALF_CYC    = 4;
endpackage : sensor_cfg_pkg

// [design/spi_link_if.sv]
`timescale 1ns/10ps
interface spi_link_if;
   logic chip_select_n;
   logic sck;
   logic host_data_out;
   logic host_data_oe;
   logic dev_data_out;
   logic dev_data_oe;
   logic serial_data_out;
   logic serial_data_in;

   // shared data line, pulled high when nobody drives
   assign serial_data_in = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 1'b1);

   modport device (input chip_select_n, sck, serial_data_in,
                   output dev_data_out, dev_data_oe, serial_data_out);
   modport host (output chip_select_n, sck, host_data_out, host_data_oe,
                 input serial_data_in, serial_data_out);
endinterface : spi_link_if

// [design/sensor_config_device.sv]
`timescale 1ns/10ps
module sensor_config_device
   import sensor_cfg_pkg::*;
#(
   parameter logic [2:0] PART_ID    = 3'h5,  // arbitrary value
   parameter logic [3:0] ANALOG_REV = 4'h1,  // arbitrary value
   parameter logic [3:0] LOGIC_REV  = 4'h2   // arbitrary value
)(
   // power-on reset
   input  wire logic       hresetn,
   // serial link, clocked by its own clock
   spi_link_if.device      link,
   // user side
   output logic            four_wire_active,
   output logic [1:0]      range_select,
   output logic [7:0]      config_image,
   output logic [7:0]      nv_wire_mode,
   output logic            frame_busy
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] cnt;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] sh;
      logic       active4;
      logic       dout;
      logic       doe;
      logic       sdo;
      logic [7:0] cfg;
      logic [7:0] nv;
      logic       fbusy;
   } dev_state_t;

   localparam dev_state_t DEV_RESET = '{
      cnt:     4'h0,
      rd:      1'b0,
      addr:    7'h00,
      sh:      8'h00,
      active4: NV_RESET[FOUR_WIRE_BIT],
      dout:    1'b1,
      doe:     1'b0,
      sdo:     1'b1,
      cfg:     CFG_RESET,
      nv:      NV_RESET,
      fbusy:   1'b0
   };

   dev_state_t s;
   dev_state_t next_s;

   // ----------------------------------------------------------------
   // register read decode
   // ----------------------------------------------------------------
   function automatic logic [7:0] read_reg(input logic [6:0] a, input dev_state_t st);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_PART_ID:  v = {5'h00, PART_ID};
         ADDR_REVISION: v = {ANALOG_REV, LOGIC_REV};
         ADDR_CONFIG:   v = st.cfg;
         ADDR_NV_WIRE:  v = st.nv;
         default:       v = 8'h00;
      endcase
      return v;
   endfunction : read_reg

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       b;
      logic [7:0] wd;
      logic [7:0] rv;
      logic [6:0] a;
      next_s = s;
      b      = link.serial_data_in;
      wd     = {s.sh[6:0], b};
      a      = {s.addr[5:0], b};
      rv     = 8'h00;
      if (!link.chip_select_n) begin
         next_s.cnt = s.cnt + 4'h1;
         if (s.cnt == 4'h0) begin
            next_s.rd      = b;
            next_s.active4 = s.cfg[FOUR_WIRE_BIT];
            next_s.doe     = 1'b0;
         end else if (s.cnt <= LAST_ADDR_BIT) begin
            next_s.addr = a;
            if (s.cnt == LAST_ADDR_BIT && s.rd) begin
               rv        = read_reg(a, s);
               next_s.sh = rv;
               if (s.active4) begin
                  next_s.sdo = rv[7];
               end else begin
                  next_s.dout = rv[7];
                  next_s.doe  = 1'b1;
               end
            end
         end else if (s.rd) begin
            if (s.cnt == LAST_FRAME_BIT) begin
               next_s.doe = 1'b0;
            end else begin
               next_s.sh = {s.sh[6:0], 1'b0};
               if (s.active4) begin
                  next_s.sdo = s.sh[6];
               end else begin
                  next_s.dout = s.sh[6];
               end
            end
         end else begin
            // write path samples only the data-in line in either mode
            next_s.sh = wd;
            if (s.cnt == LAST_FRAME_BIT) begin
               case (s.addr)
                  ADDR_CONFIG: begin
                     next_s.cfg = wd;
                     if (wd[RANGE_HI:RANGE_LO] == RANGE_INVALID) begin
                        next_s.cfg[RANGE_HI:RANGE_LO] = s.cfg[RANGE_HI:RANGE_LO];
                     end
                  end
                  ADDR_NV_WIRE: begin
                     next_s.nv                 = wd;
                     next_s.cfg[FOUR_WIRE_BIT] = wd[FOUR_WIRE_BIT];
                  end
                  ADDR_SOFT_RESET: begin
                     if (wd == SOFT_RESET_CODE) begin
                        next_s.cfg                = CFG_RESET;
                        next_s.cfg[FOUR_WIRE_BIT] = s.nv[FOUR_WIRE_BIT];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
      next_s.fbusy = (next_s.cnt != 4'h0);
   end

   // ----------------------------------------------------------------
   // registers on the link clock
   // ----------------------------------------------------------------
   // power-on reset loads CFG_RESET into the image and the stored default wire mode into four_wire_active
   always_ff @(posedge link.sck or negedge hresetn) begin
      if (!hresetn) begin
         s <= DEV_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.dev_data_out    = s.dout;
   assign link.dev_data_oe     = s.doe;
   assign link.serial_data_out = s.sdo;
   assign four_wire_active     = s.active4;
   assign range_select         = s.cfg[RANGE_HI:RANGE_LO];
   assign config_image         = s.cfg;
   assign nv_wire_mode         = s.nv;
   assign frame_busy           = s.fbusy;

endmodule : sensor_config_device

// [design/sensor_config_host.sv]
`timescale 1ns/10ps
module sensor_config_host
   import sensor_cfg_pkg::*;
#(
   parameter int SCK_HALF         = SCK_HALF_CYC,
   parameter int NV_SETTLE_CYCLES = NV_SETTLE_CYC
)(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // serial link
   spi_link_if.host         link
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      IDLE  = 3'b000,
      LEAD  = 3'b001,
      LOW   = 3'b011,
      HIGH  = 3'b010,
      TRAIL = 3'b110
   } spi_st_t;

   typedef struct packed {
      spi_st_t     st;
      logic [7:0]  div;
      logic [4:0]  bit_idx;
      logic [15:0] tx;
      logic [7:0]  rx;
      logic        cs_n;
      logic        sck;
      logic        mosi;
      logic        mosi_oe;
      logic [1:0]  sync_sdi;
      logic [1:0]  sync_sdo;
      logic        pend_wr;
      logic        pend_cmd;
      logic        refused;
      logic        id_invalid;
      logic        resync;
      logic        dev4;
      logic        nv4;
      logic [19:0] settle;
      logic [31:0] rdata;
      logic        rd;
   } host_state_t;

   host_state_t s;
   host_state_t next_s;

   function automatic logic busy(input host_state_t st);
      return (st.st != IDLE) || (st.settle != 20'h0_0000);
   endfunction : busy

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       miso;
      logic [6:0] a;
      logic [7:0] d;
      next_s          = s;
      next_s.sync_sdi = {s.sync_sdi[0], link.serial_data_in};
      next_s.sync_sdo = {s.sync_sdo[0], link.serial_data_out};
      miso            = s.dev4 ? s.sync_sdo[1] : s.sync_sdi[1];
      a               = hwdata[14:8];
      d               = hwdata[7:0];
      if (s.settle != 20'h0_0000) begin
         next_s.settle = s.settle - 20'h0_0001;
      end
      // bus address phase
      next_s.pend_wr = 1'b0;
      if (hsel && hready && htrans[1]) begin
         next_s.pend_wr  = hwrite;
         next_s.pend_cmd = (haddr[3:0] == HOST_CMD_OFS[3:0]);
         if (haddr[3:0] == HOST_STATUS_OFS[3:0]) begin
            next_s.rdata = {16'h0000, s.rx, 3'h0, s.dev4, s.resync, s.id_invalid, s.refused, busy(s)};
         end else begin
            next_s.rdata = 32'h0000_0000;
         end
      end
      // bus data phase: command write
      if (s.pend_wr && s.pend_cmd) begin
         if (busy(s)) begin
            next_s.refused = 1'b1;
         end else if (!hwdata[CMD_READ_BIT] && a == ADDR_CONFIG && d[RANGE_HI:RANGE_LO] == RANGE_INVALID) begin
            next_s.refused = 1'b1;
         end else if (!hwdata[CMD_READ_BIT] && a == ADDR_NV_WIRE && d[FOUR_WIRE_BIT] == s.nv4) begin
            next_s.refused = 1'b1;
         end else begin
            next_s.refused = 1'b0;
            next_s.tx      = {hwdata[CMD_READ_BIT], a, d};
            next_s.rd      = hwdata[CMD_READ_BIT];
            next_s.st      = LEAD;
            next_s.cs_n    = 1'b0;
            next_s.div     = 8'h00;
            next_s.bit_idx = 5'h00;
         end
      end
      // serial engine
      case (s.st)
         IDLE: begin
         end
         LEAD, HIGH: begin
            next_s.div = s.div + 8'h01;
            if (s.div == 8'(SCK_HALF - 1)) begin
               next_s.div = 8'h00;
               if (s.bit_idx == FRAME_BITS) begin
                  next_s.st      = TRAIL;
                  next_s.mosi_oe = 1'b0;
               end else begin
                  next_s.st   = LOW;
                  next_s.sck  = 1'b0;
                  next_s.mosi = s.tx[15];
                  // writes use only select, clock and data-in; a read lets go
                  // one half period after the address is sampled
                  next_s.mosi_oe = !(s.rd && s.bit_idx > 5'h07);
               end
            end
         end
         LOW: begin
            next_s.div = s.div + 8'h01;
            if (s.div == 8'(SCK_HALF - 1)) begin
               next_s.div     = 8'h00;
               next_s.st      = HIGH;
               next_s.sck     = 1'b1;
               next_s.bit_idx = s.bit_idx + 5'h01;
               next_s.tx      = {s.tx[14:0], 1'b0};
               if (s.bit_idx > 5'h07) begin
                  next_s.rx = {s.rx[6:0], miso};
               end
            end
         end
         TRAIL: begin
            next_s.div = s.div + 8'h01;
            if (s.div == 8'(SCK_HALF - 1)) begin
               next_s.st   = IDLE;
               next_s.cs_n = 1'b1;
            end
         end
         default: begin
            next_s.st = IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0] frame;
   logic        frame_end;
   host_state_t post;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame <= 16'h0000;
      end else if (s.st == IDLE && next_s.st == LEAD) begin
         frame <= next_s.tx;
      end
   end

   assign frame_end = (s.st == TRAIL) && (next_s.st == IDLE);

   always_comb begin
      post = next_s;
      if (frame_end) begin
         if (frame[15] && frame[14:8] == ADDR_PART_ID) begin
            post.id_invalid = (s.rx == ID_ALL_ONES) || (s.rx == ID_ALL_ZEROS);
         end
         if (!frame[15] && frame[14:8] == ADDR_CONFIG) begin
            post.dev4   = frame[FOUR_WIRE_BIT];
            post.resync = 1'b0;
         end
         if (!frame[15] && frame[14:8] == ADDR_NV_WIRE) begin
            post.dev4   = frame[FOUR_WIRE_BIT];
            post.nv4    = frame[FOUR_WIRE_BIT];
            post.resync = 1'b1;
            post.settle = 20'(NV_SETTLE_CYCLES);
         end
         if (!frame[15] && frame[14:8] == ADDR_SOFT_RESET && frame[7:0] == SOFT_RESET_CODE) begin
            post.dev4   = s.nv4;
            post.resync = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{st: IDLE, cs_n: 1'b1, sck: 1'b1, mosi: 1'b1, sync_sdi: 2'h3, sync_sdo: 2'h3,
                nv4: NV_RESET[FOUR_WIRE_BIT], dev4: NV_RESET[FOUR_WIRE_BIT], resync: 1'b1, default: '0};
      end else begin
         s <= post;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign hreadyout          = 1'b1;
   assign hresp              = 1'b0;
   assign hrdata             = s.rdata;
   assign link.chip_select_n = s.cs_n;
   assign link.sck           = s.sck;
   assign link.host_data_out = s.mosi;
   assign link.host_data_oe  = s.mosi_oe;

endmodule : sensor_config_host

// [verification/spi_mode_range_config_monitor.sv]
`timescale 1ns/10ps
module spi_mode_range_config_monitor (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // serial link
   input wire logic chip_select_n,
   input wire logic sck,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic serial_data_in
);
   logic [4:0] rise_cnt;
   logic       sck_q;
   logic       rd_frame;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ---------------------------------------------------------
   // frame tracking: link clock rises and the read flag
   // ---------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rise_cnt <= 5'h00;
         sck_q    <= 1'b1;
         rd_frame <= 1'b0;
      end else begin
         sck_q <= sck;
         if (chip_select_n) begin
            rise_cnt <= 5'h00;
         end else if (sck && !sck_q) begin
            rise_cnt <= rise_cnt + 5'h01;
            if (rise_cnt == 5'h00) begin
               rd_frame <= serial_data_in;
            end
         end
      end
   end

   sequence s_open;
      $fell(chip_select_n);
   endsequence
   sequence s_lead;
      sck [*3];
   endsequence
   sequence s_drive_on;
      $rose(dev_data_oe);
   endsequence

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   a_idle_sck_high: assert property (chip_select_n |-> sck)
      else $error("link clock low outside a frame");
   a_lead_sck_high: assert property (s_open |-> s_lead)
      else $error("link clock not high after select");
   a_sck_low_half: assert property ($fell(sck) |-> !sck [*3])
      else $error("link clock low phase too short");
   a_frame_ends: assert property (s_open |-> ##[100:300] $rose(chip_select_n))
      else $error("frame did not end in time");
   a_sixteen_rises: assert property ($rose(chip_select_n) |-> rise_cnt == 5'h10)
      else $error("frame did not carry sixteen clock rises");
   a_drive_read_only: assert property (dev_data_oe |-> rd_frame && !chip_select_n)
      else $error("device drives data outside a read frame");
   a_drive_at_eighth: assert property (s_drive_on |-> ##1 rise_cnt == 5'h08)
      else $error("device drive not after address bits");
   a_host_lets_go: assert property (s_drive_on |-> ##[0:8] !host_data_oe)
      else $error("host did not release the shared line");
   a_drive_released: assert property (chip_select_n |-> !dev_data_oe)
      else $error("device drives with select high");
endmodule : spi_mode_range_config_monitor

// [verification/spi_mode_range_config_tb_top.sv]
`timescale 1ns/10ps
module spi_mode_range_config_tb_top;
   import sensor_cfg_pkg::*;
   localparam logic [2:0] PART_ID = 3'h6; // arbitrary value
   localparam logic [3:0] A_REV   = 4'h3; // arbitrary value
   localparam logic [3:0] L_REV   = 4'h9; // arbitrary value
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fw_act, f_busy;
   logic [31:0] haddr, hwdata, hrdata, st;
   logic [1:0]  htrans, rng;
   logic [2:0]  hsize;
   logic [7:0]  img, nvw;
   int          bad_count, total_checks, cycles;

   spi_link_if link();
   sensor_config_host #(.SCK_HALF(4), .NV_SETTLE_CYCLES(20)) i_sensor_config_host (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .link(link));
   sensor_config_device #(.PART_ID(PART_ID), .ANALOG_REV(A_REV), .LOGIC_REV(L_REV)) i_sensor_config_device (
      .hresetn(hresetn), .link(link), .four_wire_active(fw_act), .range_select(rng),
      .config_image(img), .nv_wire_mode(nvw), .frame_busy(f_busy));
   spi_mode_range_config_monitor i_spi_mode_range_config_monitor (
      .hclk(hclk), .hresetn(hresetn), .chip_select_n(link.chip_select_n), .sck(link.sck),
      .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe),
      .serial_data_in(link.serial_data_in));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // ---------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------
   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   // one single-word transfer; read data lands in st
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      st = hrdata;
   endtask : ahb

   // one device access through the host, then poll until idle
   task dev(input logic rd, input logic [6:0] a, input logic [7:0] d);
      ahb(1'b1, HOST_CMD_OFS, {rd, 16'h0000, a, d});
      do ahb(1'b0, HOST_STATUS_OFS, 32'h0000_0000); while (st[0] !== 1'b0);
   endtask : dev

   task t_id(input logic fw);
      dev(1'b1, ADDR_PART_ID, 8'h00);
      check(st[15:8], {5'h00, PART_ID}, "part id");
      check(st[2], 1'b0, "id flagged bad");
      check(fw_act, fw, "wire mode");
      check(f_busy, 1'b0, "frame idle");
      dev(1'b1, ADDR_REVISION, 8'h00);
      check(st[15:8], {A_REV, L_REV}, "revision");
   endtask : t_id

   // ---------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------
   task t_reset;
      ahb(1'b0, HOST_STATUS_OFS, 32'h0000_0000);
      check(st[4:0], 5'h08, "status after reset");
      check(hresp, 1'b0, "okay response");
      check(img, CFG_RESET, "image at reset");
      check(nvw, NV_RESET, "store at reset");
      t_id(1'b0);
      $display("test reset done");
   endtask : t_reset

   task t_range;
      for (int i = 0; i < 3; i++) begin
         dev(1'b0, ADDR_CONFIG, {3'h0, i[1:0], 3'h0});
         check(rng, i[1:0], "range out");
         dev(1'b1, ADDR_CONFIG, 8'h00);
         check(st[15:8], {3'h0, i[1:0], 3'h0}, "range readback");
      end
      dev(1'b0, ADDR_CONFIG, {3'h0, RANGE_INVALID, 3'h0});
      check(st[1], 1'b1, "barred code refused");
      check(rng, RANGE_8G, "range kept");
      $display("test range done");
   endtask : t_range

   task t_four;
      dev(1'b0, ADDR_CONFIG, 8'h88);
      check(img, 8'h88, "image after set");
      check(fw_act, 1'b0, "mode held for the frame");
      t_id(1'b1);
      check(st[4], 1'b1, "host four wire");
      dev(1'b0, ADDR_CONFIG, 8'h80);
      check(rng, RANGE_2G, "write in four wire");
      $display("test four wire done");
   endtask : t_four

   task t_soft;
      dev(1'b0, ADDR_SOFT_RESET, SOFT_RESET_CODE);
      check(img, 8'h00, "image after soft reset");
      dev(1'b0, ADDR_CONFIG, 8'h08);
      check(rng, RANGE_4G, "write in three wire");
      t_id(1'b0);
      $display("test soft reset done");
   endtask : t_soft

   task t_store;
      dev(1'b0, ADDR_NV_WIRE, 8'h80);
      check(nvw, 8'h80, "store written");
      check(img[7], 1'b1, "image reload");
      dev(1'b0, ADDR_NV_WIRE, 8'h80);
      check(st[1], 1'b1, "repeat store refused");
      dev(1'b0, ADDR_SOFT_RESET, SOFT_RESET_CODE);
      check(img, 8'h80, "reload after soft reset");
      dev(1'b0, ADDR_CONFIG, 8'h80);
      t_id(1'b1);
      dev(1'b0, ADDR_NV_WIRE, 8'h00);
      check(nvw, 8'h00, "store cleared");
      check(img[7], 1'b0, "image cleared");
      dev(1'b0, ADDR_CONFIG, 8'h00);
      t_id(1'b0);
      $display("test store done");
   endtask : t_store

   always @(posedge hclk) begin
      cycles = cycles + 1;
      if (cycles == 40000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   initial begin
      hresetn      = 1'b0;
      hsel         = 1'b0;
      haddr        = 32'h0000_0000;
      htrans       = 2'b00;
      hwrite       = 1'b0;
      hsize        = 3'b010;
      hwdata       = 32'h0000_0000;
      bad_count    = 0;
      total_checks = 0;
      cycles       = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_range();
      t_four();
      t_soft();
      t_store();
      tally_and_finish();
   end
endmodule : spi_mode_range_config_tb_top
